// *** include/dasto_pkg.sv ***
// package: constants and types for the dual-axis torque-off unit
package dasto_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned PULSE_TOL_US = 1000;
  localparam int unsigned FILT_CYC = PULSE_TOL_US * (CLK_HZ / 1000000) + 1;
  localparam int unsigned RESP_MAX_MS = 10;
  localparam int unsigned RESP_MAX_CYC = RESP_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = TICK_MS * (CLK_HZ / 1000);
  localparam int unsigned FILT_W = 18;
  localparam int unsigned TICK_W = 24;
  localparam int unsigned DLY_W = 9;

  // delay choices in 100 ms ticks: 0, 1.4, 2.8, 5.6, 9.8, 30.8 s
  localparam logic [DLY_W-1:0] DLY_0 = 9'h000;
  localparam logic [DLY_W-1:0] DLY_1P4 = 9'h00E;
  localparam logic [DLY_W-1:0] DLY_2P8 = 9'h01C;
  localparam logic [DLY_W-1:0] DLY_5P6 = 9'h038;
  localparam logic [DLY_W-1:0] DLY_9P8 = 9'h062;
  localparam logic [DLY_W-1:0] DLY_30P8 = 9'h134;

  localparam logic [2:0] SEL_0 = 3'h0;
  localparam logic [2:0] SEL_1P4 = 3'h1;
  localparam logic [2:0] SEL_2P8 = 3'h2;
  localparam logic [2:0] SEL_5P6 = 3'h3;
  localparam logic [2:0] SEL_9P8 = 3'h4;
  localparam logic [2:0] SEL_30P8 = 3'h5;

  typedef enum logic [1:0] {
    DASTO_OFF = 2'b00,
    DASTO_RUN = 2'b01,
    DASTO_DLY = 2'b10
  } dasto_state_e;

  // one axis: inputs as seen at the pins (1 = contact closed)
  typedef struct packed {
    logic req_first;
    logic req_second;
    logic release_in;
    logic status_in;
  } dasto_axin_s;

  typedef struct packed {
    logic out_first;
    logic out_second;
    logic mon_first;
    logic mon_second;
  } dasto_axout_s;

endpackage : dasto_pkg

// *** design/dasto_axis.sv ***
// one independent torque-off axis channel
`timescale 1ns/1ns
module dasto_axis #(
  parameter logic HAS_5P6 = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire dasto_pkg::dasto_axin_s pins,
  input wire logic [2:0] delay_sel,
  input wire logic tick,
  output dasto_pkg::dasto_axout_s outs,
  output logic shutoff_state,
  output logic drive_released
);

  // ****************************************************************
  // two-flop synchronisers
  // ****************************************************************
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [2:0] sel1;
  logic [2:0] sel2;
  always_ff @(posedge clk) begin
    sync1 <= pins;
    sync2 <= sync1;
    sel1 <= delay_sel;
    sel2 <= sel1;
  end

  wire logic req_ok = sync2[3] & sync2[2];
  wire logic rel_now = sync2[1];
  wire logic status_now = sync2[0];

  // ****************************************************************
  // test pulse filter
  // ****************************************************************
  logic [dasto_pkg::FILT_W-1:0] open_cnt;
  logic shut_req;
  wire logic filt_full =
    (open_cnt >= dasto_pkg::FILT_W'(dasto_pkg::FILT_CYC - 1));
  always_ff @(posedge clk) begin
    if (srst || req_ok) begin
      open_cnt <= '0;
    end else if (!filt_full) begin
      open_cnt <= open_cnt + 1'b1;
    end
  end
  // open beyond the pulse window is a shutdown request
  assign shut_req = !req_ok && filt_full;

  // ****************************************************************
  // release edge and delay
  // ****************************************************************
  logic rel_q;
  always_ff @(posedge clk) begin
    if (srst) rel_q <= 1'b0;
    else rel_q <= rel_now;
  end
  wire logic rel_fall = rel_q & ~rel_now;

  logic [dasto_pkg::DLY_W-1:0] dly_sel;
  always_comb begin
    unique case (sel2)
      dasto_pkg::SEL_0: dly_sel = dasto_pkg::DLY_0;
      dasto_pkg::SEL_1P4: dly_sel = dasto_pkg::DLY_1P4;
      dasto_pkg::SEL_2P8: dly_sel = dasto_pkg::DLY_2P8;
      dasto_pkg::SEL_5P6:
        dly_sel = HAS_5P6 ? dasto_pkg::DLY_5P6 : dasto_pkg::DLY_0;
      dasto_pkg::SEL_9P8: dly_sel = dasto_pkg::DLY_9P8;
      dasto_pkg::SEL_30P8: dly_sel = dasto_pkg::DLY_30P8;
      default: dly_sel = dasto_pkg::DLY_0;
    endcase
  end

  // ****************************************************************
  // state machine
  // ****************************************************************
  dasto_pkg::dasto_state_e state;
  dasto_pkg::dasto_state_e next_state;
  logic [dasto_pkg::DLY_W-1:0] dly_cnt;
  logic [dasto_pkg::DLY_W-1:0] next_dly_cnt;

  always_comb begin
    next_state = state;
    next_dly_cnt = dly_cnt;
    unique case (state)
      dasto_pkg::DASTO_OFF: begin
        if (rel_fall && req_ok) next_state = dasto_pkg::DASTO_RUN;
      end
      dasto_pkg::DASTO_RUN: begin
        if (shut_req) begin
          next_dly_cnt = dly_sel;
          next_state = (dly_sel == dasto_pkg::DLY_0) ?
            dasto_pkg::DASTO_OFF : dasto_pkg::DASTO_DLY;
        end
      end
      dasto_pkg::DASTO_DLY: begin
        if (dly_cnt == '0) next_state = dasto_pkg::DASTO_OFF;
        else if (tick) next_dly_cnt = dly_cnt - 1'b1;
      end
      default: next_state = dasto_pkg::DASTO_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= dasto_pkg::DASTO_OFF;
      dly_cnt <= '0;
    end else begin
      state <= next_state;
      dly_cnt <= next_dly_cnt;
    end
  end

  // ****************************************************************
  // outputs (1 = contact closed)
  // ****************************************************************
  logic drive;
  always_ff @(posedge clk) begin
    if (srst) drive <= 1'b0;
    else drive <= (next_state != dasto_pkg::DASTO_OFF);
  end
  // one driver for the whole struct: copies cannot drift apart
  assign outs = {drive, drive, drive, drive};
  assign shutoff_state = ~drive;
  assign drive_released = status_now;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_run_open;
    state == dasto_pkg::DASTO_RUN && shut_req && dly_sel == '0;
  endsequence

  a_pair_equal: assert property (@(posedge clk) disable iff (srst)
    outs.out_first == outs.out_second && outs.mon_first == outs.out_first)
    else $error("channel copies differ");
  a_off_opens: assert property (@(posedge clk) disable iff (srst)
    state == dasto_pkg::DASTO_OFF |-> !outs.out_first)
    else $error("contact closed while shut off");
  a_zero_delay: assert property (@(posedge clk) disable iff (srst)
    s_run_open |=> !outs.out_first && state == dasto_pkg::DASTO_OFF)
    else $error("zero delay shut-off late");
  a_release_edge: assert property (@(posedge clk) disable iff (srst)
    $rose(outs.out_first) |-> $past(rel_fall))
    else $error("release without falling edge");
  a_pulse_ignored: assert property (@(posedge clk) disable iff (srst)
    $fell(req_ok) ##0 state == dasto_pkg::DASTO_RUN ##1 !req_ok[*8]
    |-> outs.out_first)
    else $error("short pulse caused shut-off");
  a_delay_hold: assert property (@(posedge clk) disable iff (srst)
    state == dasto_pkg::DASTO_DLY && dly_cnt != '0 |=> outs.out_first)
    else $error("delay cut short");
  a_mon_mirror: assert property (@(posedge clk) disable iff (srst)
    state == dasto_pkg::DASTO_OFF |-> !outs.mon_first && !outs.mon_second)
    else $error("monitor disagrees with state");
  a_reset_open: assert property (@(posedge clk)
    srst |=> !outs.out_first && !outs.mon_first)
    else $error("outputs closed after reset");

endmodule : dasto_axis

// *** design/dasto_top.sv ***
// top of the dual-axis torque-off unit
`timescale 1ns/1ns
// Functional notes
// - both torque-off outputs of an axis always carry the same value
// - torque-off contacts open in shut-off, closed when released
// - axes A and B are fully independent channels
// - drive status input: open means shut off, closed means released
// - open shutdown input requests shut-off; closed permits driving
// - both monitor outputs of an axis mirror its torque-off channel
// - monitor contacts open in shut-off, closed when released
// - torque-off delay comes from the front-panel selector switches
// - drive-status pin and its duplicate pin are one signal
// - shut-off is left only on a release input falling edge
// - delays 0,1.4,2.8,5.6,9.8,30.8 s; axis B lacks 5.6 s
// - with no delay, outputs open within 10 ms of shutdown
// - test pulses up to 1 ms on shutdown inputs are ignored
module dasto_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic axis_a_shutdown_req_first,
  input wire logic axis_a_shutdown_req_second,
  input wire logic axis_b_shutdown_req_first,
  input wire logic axis_b_shutdown_req_second,
  input wire logic axis_a_release_in,
  input wire logic axis_b_release_in,
  input wire logic axis_a_drive_status_in,
  input wire logic axis_b_drive_status_in,
  input wire logic [2:0] axis_a_delay_selector,
  input wire logic [2:0] axis_b_delay_selector,
  output logic axis_a_shutoff_out_first,
  output logic axis_a_shutoff_out_second,
  output logic axis_b_shutoff_out_first,
  output logic axis_b_shutoff_out_second,
  output logic axis_a_monitor_out_first,
  output logic axis_a_monitor_out_second,
  output logic axis_b_monitor_out_first,
  output logic axis_b_monitor_out_second,
  output logic axis_a_shutoff_state,
  output logic axis_b_shutoff_state,
  output logic axis_a_status_dup,
  output logic axis_b_status_dup
);

  // ****************************************************************
  // shared 100 ms tick for delay counting
  // ****************************************************************
  logic [dasto_pkg::TICK_W-1:0] tick_cnt;
  wire logic tick_wrap =
    (tick_cnt == dasto_pkg::TICK_W'(dasto_pkg::TICK_CYC - 1));
  always_ff @(posedge clk) begin
    if (srst || tick_wrap) tick_cnt <= '0;
    else tick_cnt <= tick_cnt + 1'b1;
  end

  // ****************************************************************
  // axis channels
  // ****************************************************************
  dasto_pkg::dasto_axin_s pins_a;
  dasto_pkg::dasto_axin_s pins_b;
  dasto_pkg::dasto_axout_s outs_a;
  dasto_pkg::dasto_axout_s outs_b;
  logic rel_a;
  logic rel_b;

  assign pins_a = {axis_a_shutdown_req_first, axis_a_shutdown_req_second,
    axis_a_release_in, axis_a_drive_status_in};
  assign pins_b = {axis_b_shutdown_req_first, axis_b_shutdown_req_second,
    axis_b_release_in, axis_b_drive_status_in};

  dasto_axis #(.HAS_5P6(1'b1)) u_axis_a (
    .clk(clk),
    .srst(srst),
    .pins(pins_a),
    .delay_sel(axis_a_delay_selector),
    .tick(tick_wrap),
    .outs(outs_a),
    .shutoff_state(axis_a_shutoff_state),
    .drive_released(rel_a)
  );

  dasto_axis #(.HAS_5P6(1'b0)) u_axis_b (
    .clk(clk),
    .srst(srst),
    .pins(pins_b),
    .delay_sel(axis_b_delay_selector),
    .tick(tick_wrap),
    .outs(outs_b),
    .shutoff_state(axis_b_shutoff_state),
    .drive_released(rel_b)
  );

  assign axis_a_shutoff_out_first = outs_a.out_first;
  assign axis_a_shutoff_out_second = outs_a.out_second;
  assign axis_a_monitor_out_first = outs_a.mon_first;
  assign axis_a_monitor_out_second = outs_a.mon_second;
  assign axis_b_shutoff_out_first = outs_b.out_first;
  assign axis_b_shutoff_out_second = outs_b.out_second;
  assign axis_b_monitor_out_first = outs_b.mon_first;
  assign axis_b_monitor_out_second = outs_b.mon_second;

  // duplicate status pin is the same synchronised signal
  assign axis_a_status_dup = rel_a;
  assign axis_b_status_dup = rel_b;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_axis_indep: assert property (@(posedge clk) disable iff (srst)
    $rose(axis_b_shutoff_out_first)
    |-> $past(axis_b_release_in, 4) && !$past(axis_b_release_in, 3))
    else $error("axis B moved with axis A");
  a_dup_follow: assert property (@(posedge clk) disable iff (srst)
    $rose(axis_a_drive_status_in) |-> ##[2:3] axis_a_status_dup)
    else $error("status duplicate not following");

endmodule : dasto_top

// *** tb/dasto_drive_model.sv ***
// behavioural model of the drive that reads one axis's torque-off pair
`timescale 1ns/1ns
module dasto_drive_model #(
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sto_first,
  input wire logic sto_second,
  output logic status
);
  // ****************************************************************
  // drive reaction
  // ****************************************************************
  logic [LAT-1:0] pipe;

  // drive runs only while both contacts are closed
  always_ff @(posedge clk) begin
    if (srst) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[LAT-2:0], sto_first & sto_second};
    end
  end

  // closed status contact means released, open means shut off
  assign status = pipe[LAT-1];
endmodule : dasto_drive_model

// *** tb/testbench.sv ***
// self-checking bench for the dual-axis torque-off unit
`timescale 1ns/1ns
module testbench;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int CYC_MAX = 140000;
  logic clk, srst, a_req, b_req, a_rel, b_rel, a_sts, b_sts;
  logic [2:0] a_sel, b_sel;
  logic a_o1, a_o2, b_o1, b_o2, a_m1, a_m2, b_m1, b_m2;
  logic a_off, b_off, a_dup, b_dup;
  dasto_pkg::dasto_axout_s a_o, b_o;
  int fail_count, n_checks, cyc, n;

  assign a_o = {a_o1, a_o2, a_m1, a_m2};
  assign b_o = {b_o1, b_o2, b_m1, b_m2};

  dasto_top dut_u (.clk(clk), .srst(srst),
    .axis_a_shutdown_req_first(a_req), .axis_a_shutdown_req_second(a_req),
    .axis_b_shutdown_req_first(b_req), .axis_b_shutdown_req_second(b_req),
    .axis_a_release_in(a_rel), .axis_b_release_in(b_rel),
    .axis_a_drive_status_in(a_sts), .axis_b_drive_status_in(b_sts),
    .axis_a_delay_selector(a_sel), .axis_b_delay_selector(b_sel),
    .axis_a_shutoff_out_first(a_o1), .axis_a_shutoff_out_second(a_o2),
    .axis_b_shutoff_out_first(b_o1), .axis_b_shutoff_out_second(b_o2),
    .axis_a_monitor_out_first(a_m1), .axis_a_monitor_out_second(a_m2),
    .axis_b_monitor_out_first(b_m1), .axis_b_monitor_out_second(b_m2),
    .axis_a_shutoff_state(a_off), .axis_b_shutoff_state(b_off),
    .axis_a_status_dup(a_dup), .axis_b_status_dup(b_dup));

  dasto_drive_model drv_a (.clk(clk), .srst(srst), .sto_first(a_o1),
    .sto_second(a_o2), .status(a_sts));
  dasto_drive_model drv_b (.clk(clk), .srst(srst), .sto_first(b_o1),
    .sto_second(b_o2), .status(b_sts));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string nm, input logic [3:0] seen,
    input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic wait_off(input bit on_b, input logic want, input int lim);
    n = 0;
    while (((on_b ? b_off : a_off) !== want) && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_off

  // release contact: connected, then opened
  task automatic release_pulse(input bit on_b);
    @(posedge clk);
    if (on_b) b_rel <= 1'b1; else a_rel <= 1'b1;
    repeat (4) @(posedge clk);
    if (on_b) b_rel <= 1'b0; else a_rel <= 1'b0;
    @(negedge clk);
  endtask : release_pulse

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    @(negedge clk);
    check("a outputs", a_o, 4'h0);
    check("b outputs", b_o, 4'h0);
    check("shutoff states", {2'h0, a_off, b_off}, 4'h3);
    check("status dups", {2'h0, a_dup, b_dup}, 4'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_release_a();
    release_pulse(1'b0);
    wait_off(1'b0, 1'b0, 10);
    check("a state", {3'h0, a_off}, 4'h0);
    check("a outputs", a_o, 4'hF);
    check("b outputs", b_o, 4'h0);
    repeat (8) @(negedge clk);
    check("a dup", {3'h0, a_dup}, 4'h1);
    $display("test release a done");
  endtask : t_release_a

  task automatic t_release_b();
    @(posedge clk);
    b_rel <= 1'b1;
    repeat (20) @(negedge clk);
    check("b level", {3'h0, b_off}, 4'h1);
    @(posedge clk);
    b_req <= 1'b0;
    release_pulse(1'b1);
    repeat (10) @(negedge clk);
    check("b open req", {3'h0, b_off}, 4'h1);
    @(posedge clk);
    b_req <= 1'b1;
    release_pulse(1'b1);
    wait_off(1'b1, 1'b0, 10);
    check("b outputs", b_o, 4'hF);
    $display("test release b done");
  endtask : t_release_b

  task automatic t_pulse_a();
    @(posedge clk);
    a_req <= 1'b0;
    repeat (1000) @(posedge clk);
    a_req <= 1'b1;
    repeat (200) @(negedge clk);
    check("a after pulse", {a_o[3:1], a_off}, 4'hE);
    $display("test pulse done");
  endtask : t_pulse_a

  task automatic t_shutdown_a();
    @(posedge clk);
    a_req <= 1'b0;
    wait_off(1'b0, 1'b1, dasto_pkg::RESP_MAX_CYC);
    check("a delay", {3'h0, (n >= dasto_pkg::FILT_CYC - 2) &&
      (n <= dasto_pkg::FILT_CYC + 10)}, 4'h1);
    check("a outputs", a_o, 4'h0);
    check("b outputs", b_o, 4'hF);
    repeat (8) @(negedge clk);
    check("a dup", {3'h0, a_dup}, 4'h0);
    $display("test shutdown done");
  endtask : t_shutdown_a

  // ****************************************************************
  // clock, timeout, main
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    srst = 1'b1;
    a_req = 1'b1;
    b_req = 1'b1;
    a_rel = 1'b0;
    b_rel = 1'b0;
    a_sel = dasto_pkg::SEL_0;
    b_sel = dasto_pkg::SEL_5P6;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_release_a();
    t_release_b();
    t_pulse_a();
    t_shutdown_a();
    stop_test();
  end
endmodule : testbench
